// File: ogb_serializer.sv
// Output serializer gearbox: parallel core words to serial bit stream.
// Assumes mode_sel and word inputs come from logic on clk_sys.
//
// Contract
// - Each top-edge cell group has one eight-to-one parallel-to-serial gearbox.
// - Modes: seven-to-one video, one eight-to-one, or two four-to-one lanes.
// - Three register stages and a final output flop sit between parallel input and serial output.
// - Stage one captures the parallel word on the slow word-rate enable.
// - Stage two hands the captured word into the bit-rate registers.
// - Stage three shifts the word out bit by bit onto the output.
`timescale 1ns/1ns
`default_nettype none
`include "ogb_params.svh"

module ogb_serializer (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic [1:0]             mode_sel,
   input  wire logic [`OGB_WORD_W-1:0] word_data,
   input  wire logic                   word_valid,
   output var  logic                   word_ready,
   output var  logic                   ser_out,
   output var  logic                   ser_out_b
);
   ogb_stream_if bus ();

   ogb_pkg::ogb_mode_t     mode_q, mode_d;
   logic [`OGB_CNT_W-1:0]  cnt_q, cnt_d;
   logic [`OGB_WORD_W-1:0] s1_q, s1_d, s2_q, s2_d;
   logic                   s1_vld_q, s1_vld_d, s2_vld_q, s2_vld_d;
   logic [`OGB_WORD_W-1:0] sh_a_q, sh_a_d;
   logic [`OGB_HALF_W-1:0] sh_b_q, sh_b_d;
   logic                   ser_a_q, ser_a_d, ser_b_q, ser_b_d;
   logic                   slow_en;

   function automatic logic [`OGB_CNT_W-1:0] ratio_of(
      input ogb_pkg::ogb_mode_t m
   );
      unique case (m)
         ogb_pkg::OGB_MODE_VIDEO7: ratio_of = `OGB_RATIO_VIDEO;
         ogb_pkg::OGB_MODE_SPLIT4: ratio_of = `OGB_RATIO_SPLIT;
         default:                  ratio_of = `OGB_RATIO_DDR8;
      endcase
   endfunction : ratio_of

   ogb_pair_buffer u_buf (
      .clk_sys (clk_sys),
      .rst     (rst),
      .s       (bus.fifo)
   );

   assign bus.in_valid  = word_valid;
   assign bus.in_data   = word_data;
   assign bus.out_ready = slow_en;
   assign word_ready    = bus.in_ready;
   assign ser_out       = ser_a_q;
   assign ser_out_b     = ser_b_q;

   always_comb begin
      // Word-rate enable from the bit-rate divider
      slow_en = (cnt_q == ratio_of(mode_q) - `OGB_CNT_ONE);
      mode_d  = mode_q;
      cnt_d   = cnt_q + `OGB_CNT_ONE;
      if (slow_en) begin
         cnt_d = `OGB_CNT_ZERO;
         mode_d = ogb_pkg::ogb_mode_t'(mode_sel);
      end
      // Stage one: capture word, or idle zero when none waits
      s1_d     = s1_q;
      s1_vld_d = s1_vld_q;
      if (slow_en) begin
         s1_vld_d = bus.out_valid;
         s1_d     = bus.out_valid ? bus.out_data : '0;
      end
      // Stage two: hand over to the bit-rate registers
      s2_d     = s2_q;
      s2_vld_d = s2_vld_q;
      if (cnt_q == `OGB_PH_STAGE2) begin
         s2_d     = s1_q;
         s2_vld_d = s1_vld_q;
      end
      // Stage three: shift, or load a fresh word per lane layout
      sh_a_d = sh_a_q >> 1;
      sh_b_d = sh_b_q >> 1;
      if (cnt_q == `OGB_PH_STAGE3) begin
         sh_a_d = '0;
         sh_b_d = '0;
         if (s2_vld_q) begin
            unique case (mode_q)
               ogb_pkg::OGB_MODE_VIDEO7: begin
                  sh_a_d = {1'b0, s2_q[6:0]};
               end
               ogb_pkg::OGB_MODE_SPLIT4: begin
                  sh_a_d = {`OGB_HALF_W'(0), s2_q[3:0]};
                  sh_b_d = s2_q[7:4];
               end
               default: begin
                  sh_a_d = s2_q;
               end
            endcase
         end
      end
      ser_a_d = sh_a_q[0];
      ser_b_d = (mode_q == ogb_pkg::OGB_MODE_SPLIT4) ? sh_b_q[0] : 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_q   <= ogb_pkg::OGB_MODE_DDR8;
         cnt_q    <= '0;
         s1_q     <= '0;
         s1_vld_q <= 1'b0;
         s2_q     <= '0;
         s2_vld_q <= 1'b0;
         sh_a_q   <= '0;
         sh_b_q   <= '0;
         ser_a_q  <= 1'b0;
         ser_b_q  <= 1'b0;
      end else begin
         mode_q   <= mode_d;
         cnt_q    <= cnt_d;
         s1_q     <= s1_d;
         s1_vld_q <= s1_vld_d;
         s2_q     <= s2_d;
         s2_vld_q <= s2_vld_d;
         sh_a_q   <= sh_a_d;
         sh_b_q   <= sh_b_d;
         ser_a_q  <= ser_a_d;
         ser_b_q  <= ser_b_d;
      end
   end
endmodule : ogb_serializer

`default_nettype wire

// File: ogb_params.svh
// Constants for the output serializer gearbox: widths, ratios, phases.
// Assumes inclusion by bare name from each file that needs them.
`ifndef OGB_PARAMS_SVH
`define OGB_PARAMS_SVH

`define OGB_WORD_W      8
`define OGB_HALF_W      4
`define OGB_CNT_W       4
`define OGB_RATIO_VIDEO 4'h7
`define OGB_RATIO_DDR8  4'h8
`define OGB_RATIO_SPLIT 4'h4
`define OGB_PH_STAGE2   4'h0
`define OGB_PH_STAGE3   4'h1
`define OGB_CNT_ZERO    4'h0
`define OGB_CNT_ONE     4'h1
`define OGB_BUF_DEPTH   2
`define OGB_BUF_PTR_W   1

`endif

// File: ogb_pkg.sv
// Types for the output serializer gearbox.
// Assumes nothing of its surroundings.
`default_nettype none
package ogb_pkg;

   typedef enum logic [1:0] {
      OGB_MODE_VIDEO7 = 2'h0,
      OGB_MODE_DDR8   = 2'h1,
      OGB_MODE_SPLIT4 = 2'h2
   } ogb_mode_t;

endpackage : ogb_pkg

`default_nettype wire

// File: ogb_stream_if.sv
// Stream carrier between the gearbox top and its two-entry buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
`include "ogb_params.svh"

interface ogb_stream_if;
   logic                   in_valid;
   logic                   in_ready;
   logic [`OGB_WORD_W-1:0] in_data;
   logic                   out_valid;
   logic                   out_ready;
   logic [`OGB_WORD_W-1:0] out_data;

   modport fifo (
      input  in_valid,
      input  in_data,
      input  out_ready,
      output in_ready,
      output out_valid,
      output out_data
   );

   modport user (
      output in_valid,
      output in_data,
      output out_ready,
      input  in_ready,
      input  out_valid,
      input  out_data
   );
endinterface : ogb_stream_if

`default_nettype wire

// File: ogb_pair_buffer.sv
// Two-entry word buffer with valid and ready on both sides.
// Assumes clk_sys and a synchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none
`include "ogb_params.svh"

module ogb_pair_buffer #(
   parameter int DEPTH = `OGB_BUF_DEPTH,
   parameter int PTR_W = `OGB_BUF_PTR_W
) (
   input  wire logic  clk_sys,
   input  wire logic  rst,
   ogb_stream_if.fifo s
);
   localparam logic [PTR_W:0]   CNT_ONE = (PTR_W+1)'(1);
   localparam logic [PTR_W:0]   CNT_MAX = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

   logic [`OGB_WORD_W-1:0] mem_q [DEPTH];
   logic [`OGB_WORD_W-1:0] mem_d [DEPTH];
   logic [PTR_W-1:0]       wr_q, wr_d, rd_q, rd_d;
   logic [PTR_W:0]         cnt_q, cnt_d;
   logic                   ready_q, ready_d;
   logic                   push, pop;

   assign s.in_ready  = ready_q;
   assign s.out_valid = (cnt_q != '0);
   assign s.out_data  = mem_q[rd_q];

   always_comb begin
      push  = s.in_valid & ready_q;
      pop   = s.out_valid & s.out_ready;
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = s.in_data;
         wr_d        = wr_q + PTR_ONE;
      end
      if (pop) begin
         rd_d = rd_q + PTR_ONE;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + CNT_ONE;
      end else if (pop && !push) begin
         cnt_d = cnt_q - CNT_ONE;
      end
      ready_d = (cnt_d != CNT_MAX);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q    <= '0;
         rd_q    <= '0;
         cnt_q   <= '0;
         ready_q <= 1'b0;
      end else begin
         mem_q   <= mem_d;
         wr_q    <= wr_d;
         rd_q    <= rd_d;
         cnt_q   <= cnt_d;
         ready_q <= ready_d;
      end
   end
endmodule : ogb_pair_buffer

`default_nettype wire

// File: ogb_serializer_properties.sv
// Port checker for the output serializer gearbox.
// Assumes a bind onto ogb_serializer, one clock and a sync reset.
`timescale 1ns/1ns
`default_nettype none
module ogb_serializer_properties (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic [1:0] mode_sel,
   input wire logic [7:0] word_data,
   input wire logic       word_valid,
   input wire logic       word_ready,
   input wire logic       ser_out,
   input wire logic       ser_out_b
);
   logic [5:0] idle_q;
   logic [5:0] nb_q;
   // Cycles since the last take and since split mode
   always_ff @(posedge clk_sys) begin
      if (rst || (word_valid && word_ready)) idle_q <= 6'h00;
      else if (idle_q != 6'h3F) idle_q <= idle_q + 6'h01;
      if (rst || mode_sel == 2'h2) nb_q <= 6'h00;
      else if (nb_q != 6'h3F) nb_q <= nb_q + 6'h01;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence take_a;
      word_valid && word_ready && mode_sel == 2'h1 && word_data != 8'h00;
   endsequence
   sequence take_b;
      word_valid && word_ready && mode_sel == 2'h2 && word_data[7:4] != 4'h0;
   endsequence
   a_start_clean: assert property ($fell(rst) |->
      !ser_out && !ser_out_b && !word_ready) else $error("not clear");
   a_ready_back: assert property ($fell(rst) |=> word_ready)
      else $error("ready not back");
   a_quiet_start: assert property ($fell(rst) |->
      (!ser_out && !ser_out_b) [*8]) else $error("early bit");
   a_take_to_a: assert property (take_a |-> ##[3:40] ser_out)
      else $error("word lost on lane a");
   a_take_to_b: assert property (take_b |-> ##[3:40] ser_out_b)
      else $error("word lost on lane b");
   a_idle_low: assert property (idle_q >= 6'h30 |-> !ser_out && !ser_out_b)
      else $error("output busy when idle");
   a_lane_b_off: assert property (nb_q >= 6'h30 |-> !ser_out_b)
      else $error("lane b busy");
endmodule : ogb_serializer_properties
bind ogb_serializer ogb_serializer_properties ogb_serializer_properties_inst (
   .clk_sys(clk_sys), .rst(rst), .mode_sel(mode_sel), .word_data(word_data),
   .word_valid(word_valid), .word_ready(word_ready), .ser_out(ser_out),
   .ser_out_b(ser_out_b));
`default_nettype wire

// File: ogb_io_buffer_model.sv
// Output buffer model: keeps the last eight bits of each lane.
// Assumes one bit per clk_sys cycle, first bit ends in bit 0.
`timescale 1ns/1ns
`default_nettype none
module ogb_io_buffer_model (
   input  wire logic       clk_sys,
   input  wire logic       ser_out,
   input  wire logic       ser_out_b,
   output var  logic [7:0] cap_a,
   output var  logic [7:0] cap_b
);
   always_ff @(posedge clk_sys) begin
      cap_a <= {ser_out, cap_a[7:1]};
      cap_b <= {ser_out_b, cap_b[7:1]};
   end
endmodule : ogb_io_buffer_model
`default_nettype wire

// File: tb_top.sv
// Testbench for the output serializer gearbox.
// Assumes the buffer model on the serial side.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic       clk_sys, rst, word_valid, word_ready, ser_out, ser_out_b;
   logic [1:0] mode_sel;
   logic [7:0] word_data, cap_a, cap_b;
   logic       full_seen;
   int         error_cnt, compares;
   ogb_serializer ogb_serializer_inst (.clk_sys(clk_sys), .rst(rst),
      .mode_sel(mode_sel), .word_data(word_data), .word_valid(word_valid),
      .word_ready(word_ready), .ser_out(ser_out), .ser_out_b(ser_out_b));
   ogb_io_buffer_model ogb_io_buffer_model_inst (.clk_sys(clk_sys),
      .ser_out(ser_out), .ser_out_b(ser_out_b), .cap_a(cap_a), .cap_b(cap_b));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task conclude;
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   task check(input logic ok, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle
   task send(input logic [7:0] w);
      int i;
      word_data <= w;
      word_valid <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         if (word_ready === 1'b1) break;
         full_seen = 1'b1;
      end
      if (i == 40) begin
         check(1'b0, 8'h00, w);
         conclude();
      end
   endtask : send
   function logic hit(input logic [1:0] m, input logic [7:0] w);
      case (m)
         2'h0: hit = cap_a[7:1] === w[6:0];
         2'h2: hit = cap_a[7:4] === w[3:0] && cap_b[7:4] === w[7:4];
         default: hit = cap_a === w;
      endcase
   endfunction : hit
   task expect_word(input logic [1:0] m, input logic [7:0] w, input int n);
      int i;
      logic f;
      f = 1'b0;
      for (i = 0; i < n && !f; i++) begin
         @(posedge clk_sys);
         #1;
         f = hit(m, w);
      end
      check(f, cap_a, w);
      if (!f) conclude();
   endtask : expect_word
   task t_modes;
      logic [1:0] m [3];
      logic [7:0] w [3];
      m = '{2'h0, 2'h2, 2'h3};
      w = '{8'hC9, 8'h99, 8'hA7};
      for (int k = 0; k < 3; k++) begin
         idle(1);
         mode_sel <= m[k];
         idle(20);
         send(w[k]);
         word_valid <= 1'b0;
         expect_word(m[k], w[k], 60);
      end
   endtask : t_modes
   task t_burst;
      idle(1);
      mode_sel <= 2'h1;
      idle(20);
      full_seen = 1'b0;
      send(8'h81);
      send(8'hC3);
      send(8'h99);
      send(8'hA5);
      word_valid <= 1'b0;
      check(full_seen, {7'h00, full_seen}, 8'h01);
      expect_word(2'h1, 8'h81, 60);
      expect_word(2'h1, 8'hC3, 8);
      expect_word(2'h1, 8'h99, 8);
      expect_word(2'h1, 8'hA5, 8);
   endtask : t_burst
   task t_reset_mid;
      idle(1);
      send(8'h3C);
      word_valid <= 1'b0;
      idle(12);
      rst <= 1'b1;
      idle(2);
      #1;
      check(!ser_out && !ser_out_b && !word_ready, cap_a, 8'h00);
      idle(1);
      rst <= 1'b0;
      idle(2);
      send(8'hB1);
      word_valid <= 1'b0;
      expect_word(2'h1, 8'hB1, 60);
   endtask : t_reset_mid
   initial begin
      rst = 1'b1;
      mode_sel = 2'h1;
      word_data = 8'h00;
      word_valid = 1'b0;
      full_seen = 1'b0;
      error_cnt = 0;
      compares = 0;
      idle(4);
      rst <= 1'b0;
      t_modes();
      t_burst();
      t_reset_mid();
      idle(60);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
